// [hw/icf_pkg.sv]
package icf_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = ADDR_W - IDX_LSB;
  localparam int NFLAG = 4;
  localparam int EXT_N = 3;
  localparam int SEL_STRIDE = 4;
  localparam int SEL_REG_W = SEL_STRIDE * EXT_N;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS [NFLAG] =
    '{14'h0ECA, 14'h0ECB, 14'h0ECC, 14'h0ECD};
  localparam logic [IDX_W-1:0] IDX_EN [NFLAG] =
    '{14'h0EC2, 14'h0EC3, 14'h0EC4, 14'h0EC5};
  localparam logic [IDX_W-1:0] IDX_PRIO [NFLAG] =
    '{14'h0EBA, 14'h0EBB, 14'h0EBC, 14'h0EBD};
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 14'h0FF2;
  localparam logic [IDX_W-1:0] IDX_PINCHG = 14'h0E80;
  localparam logic [IDX_W-1:0] IDX_EXTSEL = 14'h0E81;

  // Implemented bits per flag register, and the read-only ones
  localparam logic [REG_W-1:0] FLAG_MASK [NFLAG] =
    '{8'h37, 8'hC3, 8'hC3, 8'h33};
  localparam logic [REG_W-1:0] FLAG_RO [NFLAG] =
    '{8'h10, 8'h00, 8'h00, 8'h30};
  // Sources allowed to wake from sleep
  localparam logic [REG_W-1:0] WAKE_MASK [NFLAG] =
    '{8'hFF, 8'hBF, 8'hFF, 8'hFF};

  localparam int GIE_B = 7;
  localparam int PEIE_B = 6;
  localparam int PRIORITY_MODE_ENABLE_B = 5;
  localparam int EDGE0_B = 0;
  localparam logic [REG_W-1:0] INTERRUPT_CONTROL_MASK = 8'hE7;
  localparam logic [REG_W-1:0] INTERRUPT_CONTROL_RST = 8'h07;
  localparam logic [SEL_REG_W-1:0] EXTSEL_RST = 12'h210;

  localparam int F0 = 0;
  localparam int F1 = 1;
  localparam int F2 = 2;
  localparam int F3 = 3;
  localparam int TMR0_B = 5;
  localparam int PINCHG_B = 4;
  localparam int EXT0_B = 0;
  localparam int OSCF_B = 7;
  localparam int CSW_B = 6;
  localparam int CTHR_B = 1;
  localparam int CDONE_B = 0;
  localparam int VDET_B = 7;
  localparam int ZC_B = 6;
  localparam int CMP0_B = 0;
  localparam int RX_B = 5;
  localparam int TX_B = 4;
  localparam int BCOL_B = 1;
  localparam int SYNC_B = 0;
endpackage

// [hw/icf_interrupt_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - Priority mode: global enable passes all; hardware clears it on high take.
// - Single level: global enable passes all; hardware clears it on any take.
// - Priority mode: bit 6 gates low priority; cleared on low take.
// - Single level: bit 6 gates every peripheral source.
// - Bit 5 selects two priority levels or one level.
// - Edge select bits 0..2: one rising, zero falling.
// - Flags set on their events whatever the enables say.
// - Timer zero overflow sets bit 5; software clears it.
// - Pin change bit 4 is read-only, the OR of per-pin flags.
// - Selected edge on external input sets flag bits 0..2.
// - Single level: timer, pin change and external sources ignore peripheral enable.
// - Each external input comes from a pin chosen by a select register.
// - Oscillator failure selects internal fast oscillator and sets bit 7.
// - New oscillator ready sets clock switch bit 6; software clears.
// - Clock switch flag never wakes the device from sleep.
// - Converter threshold event sets bit 1; software clears.
// - Conversion done sets bit 0; software clears.
// - Zero-cross change sets bit 6; voltage detect sets bit 7.
// - Comparator output change sets bits 0 and 1; software clears.
// - Receive bit 5 read-only, high while receive buffer holds data.
// - Transmit bit 4 high while transmit buffer is empty.
// - Bus collision sets bit 1; software clears.
// - Sync port transfer complete sets bit 0; software clears.
module icf_interrupt_ctrl #(
  parameter int NPIN = 8,
  parameter int SEL_W = 3
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icf_pkg::ADDR_W-1:0] paddr,
  input wire logic [icf_pkg::DATA_W-1:0] pwdata,
  output logic [icf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_zero_ovf,
  input wire logic osc_fail_evt,
  input wire logic clk_switch_ready,
  input wire logic conv_threshold_evt,
  input wire logic conv_done_evt,
  input wire logic volt_detect_evt,
  input wire logic zero_cross_in,
  input wire logic [1:0] comparator_in,
  input wire logic serial_rx_full,
  input wire logic serial_tx_empty,
  input wire logic bus_collision_evt,
  input wire logic sync_port_done_evt,
  input wire logic [NPIN-1:0] pin_change_evt,
  input wire logic [NPIN-1:0] gpio_pin,
  input wire logic core_take,
  input wire logic core_take_high,
  output logic irq_high,
  output logic irq_low,
  output logic wake_req,
  output logic use_internal_fast_osc
);
  localparam int AW = NPIN + 3;
  localparam int ZC_I = NPIN;
  localparam int CMP_I = NPIN + 1;
  localparam int RW = icf_pkg::REG_W;
  localparam int NF = icf_pkg::NFLAG;

  function automatic logic hit(input logic [icf_pkg::ADDR_W-1:0] a,
                               input logic [icf_pkg::IDX_W-1:0] idx);
    hit = (a[icf_pkg::ADDR_W-1:icf_pkg::IDX_LSB] == idx);
  endfunction

  logic [RW-1:0] flags_r [NF], flags_nxt [NF], en_r [NF], prio_r [NF];
  logic [RW-1:0] set_v [NF], pend [NF], interrupt_control_r, interrupt_control_nxt, rd_byte;
  logic [NPIN-1:0] pin_r, pin_nxt;
  logic [icf_pkg::SEL_REG_W-1:0] extsel_r, rd_sel;
  logic [AW-1:0] s1_r, s2_r, s3_r, filt_r, chg;
  logic [icf_pkg::EXT_N-1:0] ext_hit;
  logic rd_sel_hit, mapped, wr_en, core_any, periph_any;
  logic hi_any, lo_any, wake_any, gie, peie, priority_mode_enable;

  assign gie = interrupt_control_r[icf_pkg::GIE_B];
  assign peie = interrupt_control_r[icf_pkg::PEIE_B];
  assign priority_mode_enable = interrupt_control_r[icf_pkg::PRIORITY_MODE_ENABLE_B];
  assign wr_en = psel & penable & pwrite & pready;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {s1_r, s2_r, s3_r, filt_r} <= '0;
    end else begin
      s1_r <= {comparator_in, zero_cross_in, gpio_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < AW; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < AW; i++) begin
      chg[i] = (s2_r[i] == s3_r[i]) && (s3_r[i] != filt_r[i]);
    end
  end

  always_comb begin
    for (int k = 0; k < icf_pkg::EXT_N; k++) begin
      logic [SEL_W-1:0] sel;
      sel = extsel_r[k*icf_pkg::SEL_STRIDE +: SEL_W];
      ext_hit[k] = 1'b0;
      if (int'(sel) < NPIN) begin
        ext_hit[k] = chg[sel] &&
          (s3_r[sel] == interrupt_control_r[icf_pkg::EDGE0_B + k]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware events
  always_comb begin
    set_v = '{default: '0};
    set_v[icf_pkg::F0][icf_pkg::TMR0_B] = timer_zero_ovf;
    set_v[icf_pkg::F0][icf_pkg::EXT0_B +: icf_pkg::EXT_N] = ext_hit;
    set_v[icf_pkg::F1][icf_pkg::OSCF_B] = osc_fail_evt;
    set_v[icf_pkg::F1][icf_pkg::CSW_B] = clk_switch_ready;
    set_v[icf_pkg::F1][icf_pkg::CTHR_B] = conv_threshold_evt;
    set_v[icf_pkg::F1][icf_pkg::CDONE_B] = conv_done_evt;
    set_v[icf_pkg::F2][icf_pkg::VDET_B] = volt_detect_evt;
    set_v[icf_pkg::F2][icf_pkg::ZC_B] = chg[ZC_I];
    set_v[icf_pkg::F2][icf_pkg::CMP0_B +: 2] = chg[CMP_I +: 2];
    set_v[icf_pkg::F3][icf_pkg::BCOL_B] = bus_collision_evt;
    set_v[icf_pkg::F3][icf_pkg::SYNC_B] = sync_port_done_evt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag registers
  always_comb begin
    logic [RW-1:0] wm;
    wm = '0;
    for (int i = 0; i < NF; i++) begin
      wm = (wr_en && hit(paddr, icf_pkg::IDX_FLAGS[i])) ?
        (icf_pkg::FLAG_MASK[i] & ~icf_pkg::FLAG_RO[i]) : '0;
      flags_nxt[i] = ((flags_r[i] & ~wm) | (pwdata[RW-1:0] & wm) |
                      set_v[i]) & icf_pkg::FLAG_MASK[i];
    end
    flags_nxt[icf_pkg::F0][icf_pkg::PINCHG_B] = |pin_nxt;
    flags_nxt[icf_pkg::F3][icf_pkg::RX_B] = serial_rx_full;
    flags_nxt[icf_pkg::F3][icf_pkg::TX_B] = serial_tx_empty;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= '{default: '0};
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_comb begin
    pin_nxt = pin_r | pin_change_evt;
    if (wr_en && hit(paddr, icf_pkg::IDX_PINCHG)) begin
      pin_nxt = pwdata[NPIN-1:0] | pin_change_evt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enables, priorities and pin select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= '{default: '0};
      prio_r <= '{default: '0};
      extsel_r <= icf_pkg::EXTSEL_RST;
    end else if (wr_en) begin
      for (int i = 0; i < NF; i++) begin
        if (hit(paddr, icf_pkg::IDX_EN[i])) begin
          en_r[i] <= pwdata[RW-1:0] & icf_pkg::FLAG_MASK[i];
        end
        if (hit(paddr, icf_pkg::IDX_PRIO[i])) begin
          prio_r[i] <= pwdata[RW-1:0] & icf_pkg::FLAG_MASK[i];
        end
      end
      if (hit(paddr, icf_pkg::IDX_EXTSEL)) begin
        extsel_r <= pwdata[icf_pkg::SEL_REG_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt control; a take in the same cycle as a write wins
  always_comb begin
    interrupt_control_nxt = interrupt_control_r;
    if (wr_en && hit(paddr, icf_pkg::IDX_INTERRUPT_CONTROL)) begin
      interrupt_control_nxt = pwdata[RW-1:0] & icf_pkg::INTERRUPT_CONTROL_MASK;
    end
    if (core_take) begin
      if (!priority_mode_enable) begin
        interrupt_control_nxt[icf_pkg::GIE_B] = 1'b0;
      end else if (core_take_high) begin
        interrupt_control_nxt[icf_pkg::GIE_B] = 1'b0;
      end else begin
        interrupt_control_nxt[icf_pkg::PEIE_B] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_control_r <= icf_pkg::INTERRUPT_CONTROL_RST;
    end else begin
      interrupt_control_r <= interrupt_control_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request generation
  always_comb begin
    {hi_any, lo_any, wake_any} = '0;
    for (int i = 0; i < NF; i++) begin
      pend[i] = flags_r[i] & en_r[i];
      hi_any = hi_any | (|(pend[i] & prio_r[i]));
      lo_any = lo_any | (|(pend[i] & ~prio_r[i]));
      wake_any = wake_any | (|(pend[i] & icf_pkg::WAKE_MASK[i]));
    end
    // first register not behind peripheral enable
    core_any = |pend[icf_pkg::F0];
    periph_any = |{pend[icf_pkg::F1], pend[icf_pkg::F2], pend[icf_pkg::F3]};
  end

  // priority mode selects the gating scheme
  // request only when all gates permit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else if (priority_mode_enable) begin
      irq_high <= gie & hi_any;
      irq_low <= gie & peie & lo_any;
    end else begin
      irq_high <= gie & (core_any | (peie & periph_any));
      irq_low <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= wake_any;
    end
  end

  // fall back to internal fast oscillator until reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      use_internal_fast_osc <= 1'b0;
    end else if (osc_fail_evt) begin
      use_internal_fast_osc <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: answer latched in setup, ready in first access cycle
  always_comb begin
    {rd_byte, rd_sel, rd_sel_hit, mapped} = '0;
    for (int i = 0; i < NF; i++) begin
      if (hit(paddr, icf_pkg::IDX_FLAGS[i])) begin
        rd_byte = flags_r[i];
        mapped = 1'b1;
      end
      if (hit(paddr, icf_pkg::IDX_EN[i])) begin
        rd_byte = en_r[i];
        mapped = 1'b1;
      end
      if (hit(paddr, icf_pkg::IDX_PRIO[i])) begin
        rd_byte = prio_r[i];
        mapped = 1'b1;
      end
    end
    if (hit(paddr, icf_pkg::IDX_INTERRUPT_CONTROL)) begin
      rd_byte = interrupt_control_r;
      mapped = 1'b1;
    end
    if (hit(paddr, icf_pkg::IDX_PINCHG)) begin
      rd_byte = '0;
      rd_byte[NPIN-1:0] = pin_r;
      mapped = 1'b1;
    end
    if (hit(paddr, icf_pkg::IDX_EXTSEL)) begin
      rd_sel = extsel_r;
      rd_sel_hit = 1'b1;
      mapped = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {pready, pslverr, prdata} <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata <= rd_sel_hit ?
          {{(icf_pkg::DATA_W-icf_pkg::SEL_REG_W){1'b0}}, rd_sel} :
          {{(icf_pkg::DATA_W-RW){1'b0}}, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence setup_phase;
    psel && !penable;
  endsequence
  sequence access_done;
    psel && penable && pready;
  endsequence

  a_apb_one_wait: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("APB ready timing wrong");
  a_apb_ready_once: assert property (
    access_done |=> !pready)
    else $error("APB ready held too long");
  a_timer_set_wins: assert property (
    timer_zero_ovf |=> flags_r[icf_pkg::F0][icf_pkg::TMR0_B])
    else $error("Timer flag event lost");
  a_single_take_clear: assert property (
    core_take && !priority_mode_enable |=> !gie ##1 !irq_high)
    else $error("Global enable not cleared on take");
  a_low_take_clear: assert property (
    core_take && priority_mode_enable && !core_take_high |=>
      !peie && (gie == $past(gie)))
    else $error("Low take handled wrongly");
  a_pin_flag_or: assert property (
    flags_r[icf_pkg::F0][icf_pkg::PINCHG_B] == (|pin_r))
    else $error("Pin change flag not OR of pins");
  a_rx_mirror: assert property (
    ##1 flags_r[icf_pkg::F3][icf_pkg::RX_B] == $past(serial_rx_full))
    else $error("Receive flag does not follow buffer");
  a_periph_gate: assert property (
    !priority_mode_enable && !peie && !core_any && $stable(interrupt_control_r) |=> !irq_high)
    else $error("Peripheral enable does not block");
  a_low_needs_gie: assert property (
    $rose(irq_low) |-> $past(gie) && $past(peie) && $past(priority_mode_enable))
    else $error("Low request without enables");
  a_no_csw_wake: assert property (
    {pend[icf_pkg::F0], pend[icf_pkg::F1] & ~(RW'(1) << icf_pkg::CSW_B),
     pend[icf_pkg::F2], pend[icf_pkg::F3]} == '0 |=> !wake_req)
    else $error("Wake without permitted source");
  a_ext0_edge: assert property (
    ext_hit[0] |=> flags_r[icf_pkg::F0][icf_pkg::EXT0_B])
    else $error("External edge not flagged");
endmodule

// [testbench/icf_core_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Core side: takes a standing request after LAT+1 cycles
module icf_core_model #(
  parameter int LAT = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic irq_high,
  input wire logic irq_low,
  output logic core_take,
  output logic core_take_high
);
  int cnt;
  // High wins over low when both stand; one pulse per take
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      core_take <= 1'b0;
      core_take_high <= 1'b0;
    end else if (core_take) begin
      core_take <= 1'b0;
      cnt <= 0;
    end else if (irq_high || irq_low) begin
      if (cnt == LAT) begin
        core_take <= 1'b1;
        core_take_high <= irq_high;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] A_F0 = 16'h3B28;
  localparam logic [15:0] A_F1 = 16'h3B2C;
  localparam logic [15:0] A_F2 = 16'h3B30;
  localparam logic [15:0] A_F3 = 16'h3B34;
  localparam logic [15:0] A_CT = 16'h3FC8;
  localparam logic [15:0] A_EN0 = 16'h3B08;
  localparam logic [15:0] A_EN1 = 16'h3B0C;
  localparam logic [15:0] A_PR1 = 16'h3AEC;
  localparam logic [15:0] A_PIN = 16'h3A00;
  localparam logic [15:0] A_SEL = 16'h3A04;
  localparam logic [15:0] EV_A [8] =
    '{A_F0, A_F1, A_F1, A_F1, A_F1, A_F2, A_F3, A_F3};
  localparam logic [7:0] EV_M [8] =
    '{8'h20, 8'h80, 8'h40, 8'h02, 8'h01, 8'h80, 8'h02, 8'h01};
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic se, zc, rxf, txe, take, take_h, irq_h, irq_l, wake, fosc;
  logic [7:0] ev, pchg, gpio;
  logic [1:0] cmp;
  int err_count, total_checks, cycles;

  icf_interrupt_ctrl icf_interrupt_ctrl_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_zero_ovf(ev[0]),
    .osc_fail_evt(ev[1]), .clk_switch_ready(ev[2]),
    .conv_threshold_evt(ev[3]), .conv_done_evt(ev[4]),
    .volt_detect_evt(ev[5]), .zero_cross_in(zc), .comparator_in(cmp),
    .serial_rx_full(rxf), .serial_tx_empty(txe),
    .bus_collision_evt(ev[6]), .sync_port_done_evt(ev[7]),
    .pin_change_evt(pchg), .gpio_pin(gpio), .core_take(take),
    .core_take_high(take_h), .irq_high(irq_h), .irq_low(irq_l),
    .wake_req(wake), .use_internal_fast_osc(fosc));
  icf_core_model #(.LAT(3)) icf_core_model_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .irq_high(irq_h), .irq_low(irq_l),
    .core_take(take), .core_take_high(take_h));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // A hang must still reach the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request held until pready is sampled high
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [15:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(string nm, logic [15:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic pulse(int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev <= 8'h00;
  endtask

  task automatic tdone(string nm);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, psel, penable, pwrite, zc, rxf, txe} = 7'h00;
    {paddr, pwdata, ev, pchg, gpio, cmp} = 74'h0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdchk("control", A_CT, 32'h07);
    rdchk("flags0", A_F0, 32'h00);
    rdchk("flags3", A_F3, 32'h00);
    apb(1'b0, 16'h0004, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    tdone("reset");
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rdchk("event_flag", EV_A[i], {24'h0, EV_M[i]});
      wr(EV_A[i], 32'h0);
      rdchk("event_clear", EV_A[i], 32'h0);
    end
    chk("fast_osc", 32'h1, {31'h0, fosc});
    zc <= 1'b1;
    cyc(8);
    rdchk("zero_cross", A_F2, 32'h40);
    cmp <= 2'b11;
    cyc(8);
    rdchk("comparators", A_F2, 32'h43);
    wr(A_F2, 32'h0);
    tdone("events");
    rxf <= 1'b1;
    txe <= 1'b1;
    cyc(2);
    rdchk("serial", A_F3, 32'h30);
    wr(A_F3, 32'hFF);
    rdchk("serial_ro", A_F3, 32'h33);
    wr(A_F3, 32'h0);
    rxf <= 1'b0;
    txe <= 1'b0;
    cyc(2);
    rdchk("serial_off", A_F3, 32'h0);
    pchg <= 8'h08;
    cyc(1);
    pchg <= 8'h00;
    rdchk("pin_change", A_F0, 32'h10);
    wr(A_F0, 32'h0);
    rdchk("pin_change_ro", A_F0, 32'h10);
    wr(A_PIN, 32'h0);
    rdchk("pin_change_clr", A_F0, 32'h0);
    tdone("serial_pins");
    gpio <= 8'h01;
    cyc(8);
    rdchk("ext_rise", A_F0, 32'h01);
    wr(A_F0, 32'h0);
    wr(A_CT, 32'h0);
    gpio <= 8'h03;
    cyc(8);
    rdchk("ext_rise_off", A_F0, 32'h0);
    gpio <= 8'h01;
    cyc(8);
    rdchk("ext_fall", A_F0, 32'h02);
    gpio <= 8'h00;
    cyc(8);
    wr(A_F0, 32'h0);
    wr(A_SEL, 32'h215);
    gpio <= 8'h20;
    cyc(8);
    gpio <= 8'h00;
    cyc(8);
    rdchk("ext_select", A_F0, 32'h01);
    tdone("external");
    // Stale flags cleared before any enable
    wr(A_F0, 32'h0);
    wr(A_F1, 32'h0);
    wr(A_EN0, 32'h20);
    wr(A_CT, 32'h80);
    pulse(0);
    cyc(10);
    rdchk("single_take", A_CT, 32'h00);
    chk("irq_drop", 32'h0, {31'h0, irq_h});
    wr(A_F0, 32'h0);
    wr(A_EN1, 32'h01);
    wr(A_CT, 32'h80);
    pulse(4);
    cyc(10);
    rdchk("periph_gated", A_CT, 32'h80);
    wr(A_CT, 32'hC0);
    cyc(10);
    rdchk("periph_take", A_CT, 32'h40);
    tdone("single");
    wr(A_F1, 32'h0);
    wr(A_EN1, 32'h40);
    pulse(2);
    cyc(4);
    chk("wake_csw", 32'h0, {31'h0, wake});
    wr(A_EN1, 32'h41);
    pulse(4);
    cyc(4);
    chk("wake_done", 32'h1, {31'h0, wake});
    wr(A_EN1, 32'h01);
    wr(A_F1, 32'h0);
    wr(A_CT, 32'hE0);
    pulse(4);
    cyc(2);
    chk("irq_low_up", 32'h1, {31'h0, irq_l});
    cyc(8);
    rdchk("low_take", A_CT, 32'hA0);
    chk("irq_low_drop", 32'h0, {31'h0, irq_l});
    wr(A_F1, 32'h0);
    wr(A_PR1, 32'h01);
    pulse(4);
    cyc(10);
    rdchk("high_take", A_CT, 32'h20);
    tdone("priority");
    complete_run();
  end
endmodule
